//--- logic/thm_pkg.sv
/*
 Constants of the thermal monitor register bank: register addresses, field
 positions, reset values, operation codes and link handshake states.
 Assumes nothing of its surroundings; it is shared by the bank itself.
*/
package thm_pkg;

   // Register addresses as the pointer holds them
   localparam logic [7:0] ADDR_LOCAL = 8'h00;
   localparam logic [7:0] ADDR_R1_HIGH = 8'h01;
   localparam logic [7:0] ADDR_CFG1_RD = 8'h03;
   localparam logic [7:0] ADDR_CFG1_WR = 8'h09;
   localparam logic [7:0] ADDR_R1_LOW = 8'h10;
   localparam logic [7:0] ADDR_CFG2 = 8'h24;
   localparam logic [7:0] ADDR_R2_HIGH = 8'h30;
   localparam logic [7:0] ADDR_R2_LOW = 8'h33;

   // Configuration one field positions
   localparam int CFG1_ALERT_MASK_BIT = 7;
   localparam int CFG1_STANDBY_BIT = 6;
   localparam int CFG1_PIN_ROLE_BIT = 5;
   localparam int CFG1_BANK_BIT = 3;
   localparam int CFG1_RANGE_BIT = 2;
   localparam int CFG1_R1_MASK_BIT = 1;
   localparam int CFG1_R2_MASK_BIT = 0;
   // Configuration two field position
   localparam int CFG2_LOCK_BIT = 7;

   // Writable bits of configuration one, and the bits a lock leaves open
   localparam logic [7:0] CFG1_WRITABLE = 8'hEF;
   localparam logic [7:0] CFG1_UNLOCKABLE = 8'h08;

   // Reset values
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [7:0] RES_RST = 8'h00;
   localparam logic [7:0] CFG1_RST = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Converter channel codes
   localparam logic [1:0] CHAN_LOCAL = 2'h0;
   localparam logic [1:0] CHAN_REMOTE_ONE = 2'h1;
   localparam logic [1:0] CHAN_REMOTE_TWO = 2'h2;

   // Result encoding: offset and ceilings of the two ranges
   localparam logic signed [10:0] EXT_OFFSET = 11'sh040;
   localparam logic signed [10:0] MAX_DEFAULT = 11'sh07F;
   localparam logic signed [10:0] MAX_EXTENDED = 11'sh0FF;

   // Operations carried across the link handshake
   typedef enum logic [2:0] {
      OP_PTR = 3'b001,
      OP_WR = 3'b010,
      OP_RD = 3'b100
   } thm_op_t;

   // Link side states
   typedef enum logic [1:0] {
      LNK_IDLE = 2'b01,
      LNK_WAIT = 2'b10
   } thm_lnk_state_t;

endpackage

//--- logic/thm_register_bank.sv
/*
 Register bank of a three-channel temperature monitor. The link side runs on
 the management bus byte engine's clock and hands each byte operation to the
 system clock by a toggle handshake; the bank, the result registers and the
 pin outputs run on the system clock. Assumes a byte engine that marks the
 first byte of each write and raises one request at a time, a converter and
 comparison logic on the system clock.
*/
// Overview of operation
// - Every register holds exactly eight bits
// - First write byte loads the address pointer
// - Next bytes write, reads return, pointed register
// - Pointer resets to 0x00, local result
// - Results written by converter only, never bus
// - Local at 0x00, remote one 0x01/0x10
// - Remote two high at 0x30, low 0x33
// - Bank bit maps remote two onto remote one
// - Bank bit stays writable under lock
// - All five results reset to 0x00
// - Configuration one read 0x03, written 0x09
// - Alert mask bit suppresses alert pin only
// - Standby stops conversions, bus keeps working
// - Overtemp and alert outputs stay driven in standby
// - Condition changes in standby update outputs
// - Pin role bit: alert or second overtemp
// - Range bit selects extended or default range
// - Remote one alert mask, resets zero
// - Remote two alert mask, resets zero
// - Lock bit freezes lockable registers
// - Lock persists until power is removed
// - Low byte read holds high until read
// - Extended range encodes temperature plus 64
`timescale 1ns/1ps
module thm_register_bank (
   input wire logic clk_i, // System clock, 100 MHz
   input wire logic rstn_i, // Power-on reset, active low
   input wire logic lnk_clk_i, // Byte engine clock
   input wire logic lnk_wr_i, // Write byte strobe, link clock
   input wire logic lnk_first_i, // Byte is the first of a write
   input wire logic [7:0] lnk_wdata_i, // Write byte
   input wire logic lnk_rd_i, // Read byte request, link clock
   output logic [7:0] lnk_rdata_o, // Read byte
   output logic lnk_rvalid_o, // Read byte valid pulse
   output logic lnk_busy_o, // Operation in flight, requests ignored
   input wire logic conv_valid_i, // Converter result pulse
   input wire logic [1:0] conv_chan_i, // Converter channel
   input wire logic signed [9:0] conv_deg_i, // Whole degrees, signed
   input wire logic [1:0] conv_frac_i, // Quarter degrees
   input wire logic alert_local_i, // Local limit violated
   input wire logic alert_remote_one_i, // Remote one limit violated
   input wire logic alert_remote_two_i, // Remote two limit violated
   input wire logic overtemp_cond_i, // Overtemperature limit exceeded
   input wire logic second_overtemp_cond_i, // Second comparator exceeded
   output logic conv_enable_o, // Conversions allowed
   output logic range_extended_o, // Extended range selected
   output logic remote_bank_o, // Remote two mapped onto remote one
   output logic lock_o, // Register lock active
   output logic overtemp_output_n_o, // Overtemperature pin, active low
   output logic shared_pin_n_o // Alert or second overtemp pin, active low
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   thm_pkg::thm_lnk_state_t lnk_state;
   thm_pkg::thm_op_t lnk_op;
   logic [7:0] lnk_data;
   logic lnk_req;
   logic ack_s1, ack_s2, ack_s3;
   logic ack_ev;
   logic req_s1, req_s2, req_s3;
   logic sys_ev;
   logic sys_ack;
   logic [7:0] sys_rdata;
   logic [7:0] pointer;
   logic [7:0] cfg_one;
   logic lock;
   logic [7:0] res_loc, res_r1h, res_r1l, res_r2h, res_r2l;
   logic frz_one, frz_two;
   logic [7:0] eff_addr;
   logic [7:0] next_cfg_one;
   logic [7:0] enc_high;
   logic alert_raw;

   // Maps the pointer onto the register it reaches under the bank bit
   function automatic logic [7:0] map_addr(input logic [7:0] ptr, input logic bank);
      logic [7:0] a;
      a = ptr;
      if (bank && ptr == thm_pkg::ADDR_R1_HIGH)
         a = thm_pkg::ADDR_R2_HIGH;
      else if (bank && ptr == thm_pkg::ADDR_R1_LOW)
         a = thm_pkg::ADDR_R2_LOW;
      return a;
   endfunction

   // Converts signed degrees into the result byte of the selected range
   function automatic logic [7:0] encode(input logic signed [9:0] deg, input logic ext);
      logic signed [10:0] v;
      logic signed [10:0] top;
      v = {deg[9], deg} + (ext ? thm_pkg::EXT_OFFSET : 11'sh000);
      top = ext ? thm_pkg::MAX_EXTENDED : thm_pkg::MAX_DEFAULT;
      if (v < 11'sh000)
         v = 11'sh000;
      else if (v > top)
         v = top;
      return v[7:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Link clock domain

   // Accepts one byte operation at a time and raises the request toggle
   always_ff @(posedge lnk_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         lnk_state <= thm_pkg::LNK_IDLE;
         lnk_op <= thm_pkg::OP_RD;
         lnk_data <= 8'h00;
         lnk_req <= 1'b0;
      end
      else
      begin
         unique case (lnk_state)
            thm_pkg::LNK_IDLE:
            begin
               if (lnk_wr_i || lnk_rd_i)
               begin
                  if (lnk_wr_i)
                     lnk_op <= lnk_first_i ? thm_pkg::OP_PTR : thm_pkg::OP_WR;
                  else
                     lnk_op <= thm_pkg::OP_RD;
                  lnk_data <= lnk_wdata_i;
                  lnk_req <= ~lnk_req;
                  lnk_state <= thm_pkg::LNK_WAIT;
               end
            end
            thm_pkg::LNK_WAIT:
            begin
               if (ack_ev)
                  lnk_state <= thm_pkg::LNK_IDLE;
            end
         endcase
      end
   end

   // Brings the acknowledge toggle into the link domain
   always_ff @(posedge lnk_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         ack_s3 <= 1'b0;
      end
      else
      begin
         ack_s1 <= sys_ack;
         ack_s2 <= ack_s1;
         ack_s3 <= ack_s2;
      end
   end

   assign ack_ev = ack_s2 ^ ack_s3;
   assign lnk_busy_o = lnk_state[1];

   // Returns the read byte, held stable by the system side until acknowledged
   always_ff @(posedge lnk_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         lnk_rdata_o <= 8'h00;
         lnk_rvalid_o <= 1'b0;
      end
      else
      begin
         lnk_rvalid_o <= ack_ev && lnk_state == thm_pkg::LNK_WAIT && lnk_op == thm_pkg::OP_RD;
         if (ack_ev && lnk_op == thm_pkg::OP_RD)
            lnk_rdata_o <= sys_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Handshake into the system clock domain

   // Request toggle synchroniser; op and data are stable while it is in flight
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_s3 <= 1'b0;
      end
      else
      begin
         req_s1 <= lnk_req;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
      end
   end

   assign sys_ev = req_s2 ^ req_s3;
   assign eff_addr = map_addr(pointer, cfg_one[thm_pkg::CFG1_BANK_BIT]);

   ////////////////////////////////////////////////////////////////////////
   // Address pointer and read path

   // Loads the pointer from the first byte of every write
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         pointer <= thm_pkg::PTR_RST;
      else if (sys_ev && lnk_op == thm_pkg::OP_PTR)
         pointer <= lnk_data;
   end

   // Captures the pointed register and acknowledges every operation
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         sys_rdata <= 8'h00;
         sys_ack <= 1'b0;
      end
      else if (sys_ev)
      begin
         sys_ack <= ~sys_ack;
         if (lnk_op == thm_pkg::OP_RD)
         begin
            unique case (eff_addr)
               thm_pkg::ADDR_LOCAL: sys_rdata <= res_loc;
               thm_pkg::ADDR_R1_HIGH: sys_rdata <= res_r1h;
               thm_pkg::ADDR_R1_LOW: sys_rdata <= res_r1l;
               thm_pkg::ADDR_R2_HIGH: sys_rdata <= res_r2h;
               thm_pkg::ADDR_R2_LOW: sys_rdata <= res_r2l;
               thm_pkg::ADDR_CFG1_RD: sys_rdata <= cfg_one;
               thm_pkg::ADDR_CFG2: sys_rdata <= {lock, 7'h00};
               default: sys_rdata <= thm_pkg::READ_UNMAPPED;
            endcase
         end
      end
   end

   // Low byte read holds the pair until the high byte is read
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         frz_one <= 1'b0;
         frz_two <= 1'b0;
      end
      else if (sys_ev && lnk_op == thm_pkg::OP_RD)
      begin
         if (eff_addr == thm_pkg::ADDR_R1_LOW)
            frz_one <= 1'b1;
         else if (eff_addr == thm_pkg::ADDR_R1_HIGH)
            frz_one <= 1'b0;
         if (eff_addr == thm_pkg::ADDR_R2_LOW)
            frz_two <= 1'b1;
         else if (eff_addr == thm_pkg::ADDR_R2_HIGH)
            frz_two <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers

   // Next configuration one value; the lock leaves only the bank bit open
   always_comb
   begin
      if (lock)
         next_cfg_one = (cfg_one & ~thm_pkg::CFG1_UNLOCKABLE)
            | (lnk_data & thm_pkg::CFG1_UNLOCKABLE);
      else
         next_cfg_one = lnk_data & thm_pkg::CFG1_WRITABLE;
   end

   // Configuration one is written only at its write address
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cfg_one <= thm_pkg::CFG1_RST;
      else if (sys_ev && lnk_op == thm_pkg::OP_WR && pointer == thm_pkg::ADDR_CFG1_WR)
         cfg_one <= next_cfg_one;
   end

   // Lock sets on a one in its bit and clears only at power-on reset
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         lock <= 1'b0;
      else if (sys_ev && lnk_op == thm_pkg::OP_WR && pointer == thm_pkg::ADDR_CFG2
               && lnk_data[thm_pkg::CFG2_LOCK_BIT])
         lock <= 1'b1;
   end

   assign lock_o = lock;
   assign range_extended_o = cfg_one[thm_pkg::CFG1_RANGE_BIT];
   assign remote_bank_o = cfg_one[thm_pkg::CFG1_BANK_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Result registers, written by the converter alone

   assign enc_high = encode(conv_deg_i, cfg_one[thm_pkg::CFG1_RANGE_BIT]);

   // Stores results unless in standby or held by a pending pair read
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         res_loc <= thm_pkg::RES_RST;
         res_r1h <= thm_pkg::RES_RST;
         res_r1l <= thm_pkg::RES_RST;
         res_r2h <= thm_pkg::RES_RST;
         res_r2l <= thm_pkg::RES_RST;
      end
      else if (conv_valid_i && !cfg_one[thm_pkg::CFG1_STANDBY_BIT])
      begin
         if (conv_chan_i == thm_pkg::CHAN_LOCAL)
            res_loc <= enc_high;
         else if (conv_chan_i == thm_pkg::CHAN_REMOTE_ONE && !frz_one)
         begin
            res_r1h <= enc_high;
            res_r1l <= {conv_frac_i, 6'h00};
         end
         else if (conv_chan_i == thm_pkg::CHAN_REMOTE_TWO && !frz_two)
         begin
            res_r2h <= enc_high;
            res_r2l <= {conv_frac_i, 6'h00};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin outputs, evaluated every cycle, standby included

   assign alert_raw = alert_local_i
      || (alert_remote_one_i && !cfg_one[thm_pkg::CFG1_R1_MASK_BIT])
      || (alert_remote_two_i && !cfg_one[thm_pkg::CFG1_R2_MASK_BIT]);

   // Drives the overtemp pin and the shared pin in its selected role
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         overtemp_output_n_o <= 1'b1;
         shared_pin_n_o <= 1'b1;
         conv_enable_o <= 1'b0;
      end
      else
      begin
         overtemp_output_n_o <= ~overtemp_cond_i;
         conv_enable_o <= ~cfg_one[thm_pkg::CFG1_STANDBY_BIT];
         if (cfg_one[thm_pkg::CFG1_PIN_ROLE_BIT])
            shared_pin_n_o <= ~second_overtemp_cond_i;
         else
            shared_pin_n_o <= ~(alert_raw && !cfg_one[thm_pkg::CFG1_ALERT_MASK_BIT]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   sequence rd_at(logic [7:0] a);
      sys_ev && lnk_op == thm_pkg::OP_RD && eff_addr == a;
   endsequence

   sequence wr_at(logic [7:0] a);
      sys_ev && lnk_op == thm_pkg::OP_WR && pointer == a;
   endsequence

   ptr_load_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      sys_ev && lnk_op == thm_pkg::OP_PTR |=> pointer == $past(lnk_data))
      else $error("pointer not loaded from first write byte");

   local_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_at(thm_pkg::ADDR_LOCAL) |=> sys_rdata == $past(res_loc))
      else $error("local result not returned");

   bank_remap_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      sys_ev && lnk_op == thm_pkg::OP_RD && pointer == thm_pkg::ADDR_R1_HIGH
      && cfg_one[thm_pkg::CFG1_BANK_BIT] |=> sys_rdata == $past(res_r2h))
      else $error("bank select did not map remote two");

   cfg_rd_only_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_at(thm_pkg::ADDR_CFG1_RD) |=> $stable(cfg_one))
      else $error("configuration one changed by write to read address");

   bank_unlocked_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_at(thm_pkg::ADDR_CFG1_WR) ##0 lock |=> cfg_one[thm_pkg::CFG1_BANK_BIT]
      == $past(lnk_data[thm_pkg::CFG1_BANK_BIT]) && cfg_one[7:4] == $past(cfg_one[7:4]))
      else $error("locked write misbehaved");

   lock_sticky_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      lock |=> lock [*8])
      else $error("lock cleared before power-down");

   standby_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cfg_one[thm_pkg::CFG1_STANDBY_BIT] && !sys_ev |=> $stable(res_loc)
      && $stable(res_r1h) && $stable(res_r2h) && !conv_enable_o)
      else $error("result changed in standby");

   alert_mask_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cfg_one[thm_pkg::CFG1_ALERT_MASK_BIT] && !cfg_one[thm_pkg::CFG1_PIN_ROLE_BIT]
      && $stable(cfg_one) |=> shared_pin_n_o)
      else $error("alert asserted while masked");

   pair_freeze_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_at(thm_pkg::ADDR_R1_LOW) ##1 !(sys_ev && lnk_op == thm_pkg::OP_RD
      && eff_addr == thm_pkg::ADDR_R1_HIGH) |=> $stable(res_r1h))
      else $error("remote one high byte changed after low byte read");

   reserved_zero_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cfg_one[4] == 1'b0)
      else $error("reserved configuration bit set");

   lnk_done_a: assert property (@(posedge lnk_clk_i) disable iff (!rstn_i)
      lnk_state == thm_pkg::LNK_IDLE && (lnk_wr_i || lnk_rd_i) |=> lnk_busy_o ##[1:12] !lnk_busy_o)
      else $error("link operation not acknowledged");

endmodule // thm_register_bank

//--- sim/thermal_monitor_register_bank_tb.sv
/*
 Self-checking bench of the thermal monitor register bank.
 Assumes the host model drives the link; converter and pin inputs are driven here.
*/
`timescale 1ns/1ps
module thermal_monitor_register_bank_tb;
   logic clk_i = 1'h0;
   logic rstn_i = 1'h0;
   logic free_clk = 1'h0;
   logic lnk_clk, lnk_wr, lnk_first, lnk_rd, lnk_rvalid, lnk_busy;
   logic [7:0] lnk_wdata, lnk_rdata;
   logic conv_valid = 1'h0;
   logic [1:0] conv_chan = 2'h0;
   logic signed [9:0] conv_deg = 10'h000;
   logic [1:0] conv_frac = 2'h0;
   logic al_loc = 1'h0, al_r1 = 1'h0, al_r2 = 1'h0, ot = 1'h0, ot2 = 1'h0;
   logic conv_en, rng, bank, lock, ot_n, sh_n;
   int num_errors = 0;
   int cmp_count = 0;
   // System clock 100 MHz
   always #5 clk_i = ~clk_i;
   // Link clock 30 ns, phase unrelated
   initial
   begin
      #3.7;
      forever #15 free_clk = ~free_clk;
   end
   thm_host_model u_host (.free_clk_i(free_clk), .lnk_clk_o(lnk_clk), .lnk_wr_o(lnk_wr),
      .lnk_first_o(lnk_first), .lnk_wdata_o(lnk_wdata), .lnk_rd_o(lnk_rd),
      .lnk_rdata_i(lnk_rdata), .lnk_rvalid_i(lnk_rvalid), .lnk_busy_i(lnk_busy));
   thm_register_bank uut (.clk_i(clk_i), .rstn_i(rstn_i), .lnk_clk_i(lnk_clk),
      .lnk_wr_i(lnk_wr), .lnk_first_i(lnk_first), .lnk_wdata_i(lnk_wdata), .lnk_rd_i(lnk_rd),
      .lnk_rdata_o(lnk_rdata), .lnk_rvalid_o(lnk_rvalid), .lnk_busy_o(lnk_busy),
      .conv_valid_i(conv_valid), .conv_chan_i(conv_chan), .conv_deg_i(conv_deg),
      .conv_frac_i(conv_frac), .alert_local_i(al_loc), .alert_remote_one_i(al_r1),
      .alert_remote_two_i(al_r2), .overtemp_cond_i(ot), .second_overtemp_cond_i(ot2),
      .conv_enable_o(conv_en), .range_extended_o(rng), .remote_bank_o(bank), .lock_o(lock),
      .overtemp_output_n_o(ot_n), .shared_pin_n_o(sh_n));
   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic summarize();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Compare one byte
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One link operation; a missing answer ends the run
   task automatic xfer(input logic wr, input logic first, input logic [7:0] d,
                       output logic [7:0] q);
      logic ok;
      u_host.op(wr, first, d, q, ok);
      if (!ok)
      begin
         num_errors++;
         $display("[ERR] link answer expected 1 seen 0");
         summarize();
      end
   endtask
   // Pointer byte then data byte
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'h1, 1'h1, a, q);
      xfer(1'h1, 1'h0, d, q);
   endtask
   // Pointer byte then read, compared
   task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      xfer(1'h1, 1'h1, a, q);
      xfer(1'h0, 1'h0, 8'h00, q);
      chk($sformatf("reg %h", a), exp, q);
   endtask
   // One converter result pulse
   task automatic conv(input logic [1:0] ch, input logic signed [9:0] deg,
                       input logic [1:0] fr);
      @(negedge clk_i);
      conv_valid = 1'h1;
      conv_chan = ch;
      conv_deg = deg;
      conv_frac = fr;
      @(negedge clk_i);
      conv_valid = 1'h0;
      conv_deg = ~deg;
   endtask
   // Set {local, remote one, remote two, overtemp, second} conditions, check {overtemp_n, shared_n}
   task automatic pins(input logic [4:0] c, input logic [1:0] exp);
      @(negedge clk_i);
      {al_loc, al_r1, al_r2, ot, ot2} = c;
      repeat (2) @(negedge clk_i);
      chk("pins", {6'h00, exp}, {6'h00, ot_n, sh_n});
   endtask
   // Control outputs {lock, bank, range, conv_enable}
   task automatic ctrl(input logic [3:0] exp);
      chk("ctrl", {4'h0, exp}, {4'h0, lock, bank, rng, conv_en});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Power-on state: read without pointer write gives local result
   task automatic t_reset();
      logic [7:0] q;
      xfer(1'h0, 1'h0, 8'h00, q);
      chk("first read", 8'h00, q);
      ctrl(4'h1);
      rreg(8'h10, 8'h00);
      rreg(8'h01, 8'h00);
      rreg(8'h33, 8'h00);
      rreg(8'h30, 8'h00);
      pins(5'h00, 2'h3);
   endtask
   // Converter results at their addresses; bus writes cannot change them
   task automatic t_results();
      conv(2'h0, 10'sd25, 2'h0);
      conv(2'h1, 10'sd100, 2'h2);
      conv(2'h2, 10'sd10, 2'h3);
      rreg(8'h00, 8'h19);
      rreg(8'h10, 8'h80);
      rreg(8'h01, 8'h64);
      rreg(8'h33, 8'hC0);
      rreg(8'h30, 8'h0A);
      wreg(8'h00, 8'hFF);
      wreg(8'h30, 8'h55);
      rreg(8'h00, 8'h19);
      rreg(8'h30, 8'h0A);
      conv(2'h0, 10'sd200, 2'h0);
      rreg(8'h00, 8'h7F);
   endtask
   // Low byte read holds the high byte until it is read
   task automatic t_freeze();
      rreg(8'h10, 8'h80);
      conv(2'h1, 10'sd50, 2'h1);
      rreg(8'h01, 8'h64);
      conv(2'h1, 10'sd50, 2'h1);
      rreg(8'h10, 8'h40);
      rreg(8'h01, 8'h32);
   endtask
   // Split addresses, reserved bit, standby, bank remap, pin role
   task automatic t_config();
      wreg(8'h09, 8'hFF);
      rreg(8'h03, 8'hEF);
      rreg(8'h09, 8'h00);
      wreg(8'h03, 8'h00);
      rreg(8'h03, 8'hEF);
      ctrl(4'h6);
      conv(2'h0, 10'sd30, 2'h0);
      rreg(8'h00, 8'h7F);
      rreg(8'h01, 8'h0A);
      pins(5'h03, 2'h0);
      pins(5'h10, 2'h3);
   endtask
   // Extended range encoding and alert masks
   task automatic t_alert();
      wreg(8'h09, 8'h04);
      ctrl(4'h3);
      conv(2'h0, 10'sd25, 2'h0);
      rreg(8'h00, 8'h59);
      wreg(8'h09, 8'h07);
      pins(5'h08, 2'h3);
      pins(5'h04, 2'h3);
      pins(5'h10, 2'h2);
      wreg(8'h09, 8'h84);
      pins(5'h10, 2'h3);
      wreg(8'h09, 8'h04);
      pins(5'h08, 2'h2);
      pins(5'h04, 2'h2);
      pins(5'h00, 2'h3);
   endtask
   // Lock freezes all but the bank bit and cannot be cleared
   task automatic t_lock();
      wreg(8'h24, 8'h80);
      rreg(8'h24, 8'h80);
      ctrl(4'hB);
      wreg(8'h09, 8'h08);
      rreg(8'h03, 8'h0C);
      wreg(8'h09, 8'h00);
      rreg(8'h03, 8'h04);
      wreg(8'h24, 8'h00);
      rreg(8'h24, 8'h80);
   endtask
   // Power-on reset in mid-run is the only way out of the lock
   task automatic t_power();
      logic [7:0] q;
      @(negedge clk_i);
      rstn_i = 1'h0;
      repeat (5) @(negedge clk_i);
      rstn_i = 1'h1;
      repeat (4) @(negedge clk_i);
      ctrl(4'h1);
      xfer(1'h0, 1'h0, 8'h00, q);
      chk("read after reset", 8'h00, q);
      rreg(8'h24, 8'h00);
      rreg(8'h03, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (5) @(negedge clk_i);
      rstn_i = 1'h1;
      repeat (4) @(negedge clk_i);
      t_reset();
      t_results();
      t_freeze();
      t_config();
      t_alert();
      t_lock();
      t_power();
      summarize();
   end
endmodule // thermal_monitor_register_bank_tb

//--- sim/thm_host_model.sv
/*
 Host side of the byte link: pointer, write and read byte operations.
 Assumes a free 30 ns clock from the bench; it is gated here between frames.
*/
`timescale 1ns/1ps
module thm_host_model (
   input wire logic free_clk_i, // Free running link clock
   output logic lnk_clk_o, // Gated link clock
   output logic lnk_wr_o, // Write byte strobe
   output logic lnk_first_o, // First byte of a write
   output logic [7:0] lnk_wdata_o, // Write byte
   output logic lnk_rd_o, // Read byte request
   input wire logic [7:0] lnk_rdata_i, // Read byte
   input wire logic lnk_rvalid_i, // Read byte valid
   input wire logic lnk_busy_i // Operation in flight
);
   logic run;
   // Gate changes only while the free clock is low, so no slivers appear
   assign lnk_clk_o = free_clk_i & run;
   // Idle state; clock runs through reset
   initial
   begin
      run = 1'h1;
      lnk_wr_o = 1'h0;
      lnk_first_o = 1'h0;
      lnk_wdata_o = 8'hA5;
      lnk_rd_o = 1'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One byte operation; ok stays low if no answer comes in 12 cycles
   task automatic op(input logic wr, input logic first, input logic [7:0] d,
                     output logic [7:0] q, output logic ok);
      int n;
      @(negedge free_clk_i);
      run = 1'h1;
      @(negedge free_clk_i);
      lnk_wr_o = wr;
      lnk_rd_o = ~wr;
      lnk_first_o = first;
      lnk_wdata_o = d;
      @(negedge free_clk_i);
      lnk_wr_o = 1'h0;
      lnk_rd_o = 1'h0;
      lnk_first_o = ~first;
      lnk_wdata_o = ~d; // Released byte shows no stale value
      ok = 1'h0;
      q = 8'h00;
      for (n = 0; n < 12; n++)
      begin
         @(negedge free_clk_i);
         if (lnk_busy_i === 1'h0)
         begin
            ok = wr | (lnk_rvalid_i === 1'h1);
            q = lnk_rdata_i;
            break;
         end
      end
      if (ok)
         run = 1'h0; // Clock stands still between frames
   endtask
endmodule // thm_host_model
